// ==== logic/dma_link_if.sv ====
// connection between the dma device end and its host end
`timescale 1ns/1ns
interface dma_link_if;
  // apb register bus, host is master
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // system bus, dma is master
  logic mem_req;
  logic mem_we;
  logic [31:0] mem_addr;
  logic [3:0] mem_be;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic mem_ack;
  // peripheral flow control
  logic [15:0] periph_req;
  logic [15:0] periph_ack;
  modport dev (
    input psel, penable, pwrite, paddr, pwdata,
    output prdata, pready, pslverr,
    output mem_req, mem_we, mem_addr, mem_be, mem_wdata,
    input mem_rdata, mem_ack,
    input periph_req,
    output periph_ack
  );
  modport host (
    output psel, penable, pwrite, paddr, pwdata,
    input prdata, pready, pslverr,
    input mem_req, mem_we, mem_addr, mem_be, mem_wdata,
    output mem_rdata, mem_ack,
    output periph_req,
    input periph_ack
  );
endinterface : dma_link_if

// ==== logic/dma_ll_device.sv ====
// dma controller with paired-channel linked-list sequencing
`timescale 1ns/1ns
module dma_ll_device
  import dma_ll_pkg::*;
#(
  parameter int NCH = NCH_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to host side
  dma_link_if.dev lnk,
  // user side
  output logic irq,
  output logic [NCH-1:0] chan_active
);
  typedef enum {ST_IDLE, ST_READ, ST_WRITE} state_type;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  state_type st_r;
  logic [CW-1:0] sel_r;
  logic [31:0] data_r;
  logic [31:0] src_r [NCH];
  logic [31:0] dst_r [NCH];
  logic [31:0] len_r [NCH];
  logic [31:0] cfg_r [NCH];
  logic [31:0] cnt_r [NCH];
  logic [31:0] csrc_r [NCH];
  logic [31:0] cdst_r [NCH];
  logic [NCH-1:0] en_r, en_nxt, start, rdy;
  logic [31:0] stat_r, stat_nxt, mask_r;

  function automatic logic [31:0] step(input logic [1:0] sz);
    case (sz)
      SIZE_BYTE: step = 32'h0000_0001;
      SIZE_HALF: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
  endfunction : step

  function automatic logic [3:0] lanes(input logic [1:0] sz,
                                       input logic [1:0] a);
    case (sz)
      SIZE_BYTE: lanes = 4'h1 << a;
      SIZE_HALF: lanes = a[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  endfunction : lanes

  // element picked from its lane and copied to every lane, so the
  // write side can land it at any alignment
  function automatic logic [31:0] spread(input logic [31:0] d,
                                         input logic [1:0] sz,
                                         input logic [1:0] a);
    logic [31:0] s;
    s = d >> {a, 3'h0};
    case (sz)
      SIZE_BYTE: spread = {4{s[7:0]}};
      SIZE_HALF: spread = {2{s[15:0]}};
      default: spread = d;
    endcase
  endfunction : spread

  function automatic logic [3:0] psel_of(input logic [31:0] c,
                                         input int lsb);
    psel_of = c[lsb +: 4];
  endfunction : psel_of

  function automatic logic in_window(input logic [31:0] a);
    in_window = (a[31:12] == REG_PAGE);
  endfunction : in_window

  // selected channel and its fields
  wire [31:0] s_cfg = cfg_r[sel_r];
  wire [1:0] s_size = s_cfg[CFG_SIZE_LSB +: 2];
  wire [3:0] s_ssel = psel_of(s_cfg, CFG_SSEL_LSB);
  wire [3:0] s_dsel = psel_of(s_cfg, CFG_DSEL_LSB);
  wire [2:0] s_pch = s_cfg[CFG_PCH_LSB +: 3];
  wire s_pen = s_cfg[CFG_PEN_BIT];
  wire s_circ = s_cfg[CFG_CIRC_BIT];
  wire [31:0] s_src = csrc_r[sel_r];
  wire [31:0] s_dst = cdst_r[sel_r];
  wire s_last = (cnt_r[sel_r] == len_r[sel_r]);
  wire s_half = (cnt_r[sel_r] == (len_r[sel_r] >> 1));
  wire dst_int = in_window(s_dst);

  // one element finished when its write lands; writes into our own
  // register window take a single cycle and never reach the bus
  wire int_wr = (st_r == ST_WRITE) && dst_int;
  wire xfer_done = (st_r == ST_WRITE) && (dst_int || lnk.mem_ack);
  wire blk_done = xfer_done && s_last;

  // peripheral pacing: a zero select means memory, always ready
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      logic [3:0] ss;
      logic [3:0] ds;
      ss = psel_of(cfg_r[c], CFG_SSEL_LSB);
      ds = psel_of(cfg_r[c], CFG_DSEL_LSB);
      rdy[c] = en_r[c] && (ss == 4'h0 || lnk.periph_req[ss])
               && (ds == 4'h0 || lnk.periph_req[ds]);
    end
  end

  // lowest ready channel wins the single bus port
  logic [CW-1:0] pick;
  logic pick_ok;
  always_comb begin
    pick = '0;
    pick_ok = 1'b0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (rdy[c]) begin
        pick = CW'(c);
        pick_ok = 1'b1;
      end
    end
  end

  // bus master outputs
  assign lnk.mem_req = (st_r == ST_READ) || ((st_r == ST_WRITE) && !dst_int);
  assign lnk.mem_we = (st_r == ST_WRITE);
  assign lnk.mem_addr = (st_r == ST_WRITE) ? s_dst : s_src;
  assign lnk.mem_be = lanes(s_size, lnk.mem_addr[1:0]);
  assign lnk.mem_wdata = data_r;
  assign lnk.periph_ack = xfer_done ?
    (NPERIPH'(1) << s_ssel | NPERIPH'(1) << s_dsel) & 16'hFFFE : 16'h0000;

  // register write port: the dma's own writes take precedence and
  // stall apb for that one cycle, so neither write is lost
  wire apb_acc = lnk.psel && lnk.penable;
  wire [11:0] p_off = lnk.paddr[11:0];
  assign lnk.pready = !int_wr;
  wire rw_en = int_wr || (apb_acc && lnk.pwrite && !int_wr);
  wire [11:0] rw_off = int_wr ? s_dst[11:0] : p_off;
  wire [31:0] rw_data = int_wr ? data_r : lnk.pwdata;
  wire rw_chan = (rw_off[11:8] == WIN_CHAN);
  wire rw_alt = (rw_off[11:8] == WIN_ALT);
  wire [2:0] rw_ch = rw_chan ? rw_off[CH_IDX_LSB +: 3]
                             : rw_off[ALT_IDX_LSB +: 3];
  wire [2:0] rw_reg = rw_chan ? rw_off[4:2] : {1'b0, rw_off[3:2]};

  // address map check
  logic p_map;
  logic [31:0] p_rd;
  wire [2:0] p_ch = p_off[CH_IDX_LSB +: 3];
  always_comb begin
    p_map = 1'b1;
    p_rd = 32'h0000_0000;
    if (p_off[11:8] == WIN_CHAN && p_ch < NCH && p_off[1:0] == 2'h0) begin
      case (p_off[4:2])
        REG_SRC: p_rd = src_r[p_ch[CW-1:0]];
        REG_DST: p_rd = dst_r[p_ch[CW-1:0]];
        REG_LEN: p_rd = len_r[p_ch[CW-1:0]];
        REG_CFG: p_rd = cfg_r[p_ch[CW-1:0]];
        REG_CNT: p_rd = cnt_r[p_ch[CW-1:0]];
        default: p_map = 1'b0;
      endcase
    end else begin
      case (p_off)
        OFF_ENABLE: p_rd = 32'(en_r);
        OFF_STAT: p_rd = stat_r;
        OFF_MASK: p_rd = mask_r;
        OFF_SOFTINT: p_rd = 32'(stat_r[STAT_SOFT_BIT]);
        default: p_map = 1'b0;
      endcase
    end
  end
  assign lnk.prdata = p_rd;
  assign lnk.pslverr = apb_acc && !p_map;

  // enable and status next values
  always_comb begin
    en_nxt = en_r;
    stat_nxt = stat_r;
    if (rw_en && rw_off == OFF_ENABLE) begin
      en_nxt = rw_data[NCH-1:0];
    end
    if (rw_en && rw_off == OFF_STAT) begin
      stat_nxt = stat_r & ~rw_data;
    end
    if (rw_en && rw_off == OFF_SOFTINT) begin
      stat_nxt[STAT_SOFT_BIT] = 1'b1;
    end
    if (xfer_done && s_half) begin
      stat_nxt[2 * sel_r + 1] = 1'b1;
    end
    if (blk_done) begin
      stat_nxt[2 * sel_r] = 1'b1;
      if (!s_circ) begin
        en_nxt[sel_r] = 1'b0;
      end
      if (s_pen && s_pch < NCH) begin
        en_nxt[s_pch[CW-1:0]] = 1'b1;
      end
    end
  end
  assign start = en_nxt & ~en_r;
  // masked bits stay silent; a fully masked list channel never shows
  assign irq = |(stat_r & ~mask_r);
  assign chan_active = en_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= '0;
      stat_r <= STAT_RST;
      mask_r <= MASK_RST;
    end else begin
      en_r <= en_nxt;
      stat_r <= stat_nxt;
      if (rw_en && rw_off == OFF_MASK) begin
        mask_r <= rw_data;
      end
    end
  end

  // transfer sequencer: read an element, then write it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
      sel_r <= '0;
      data_r <= 32'h0000_0000;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (pick_ok) begin
            sel_r <= pick;
            st_r <= ST_READ;
          end
        end
        ST_READ: begin
          if (lnk.mem_ack) begin
            data_r <= spread(lnk.mem_rdata, s_size, s_src[1:0]);
            st_r <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (xfer_done) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // channel registers; the alternate window aliases the working set
  // and is laid out so five words walk block src, dst,
  // len, cfg and then the next channel's src
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NCH; c++) begin
        src_r[c] <= 32'h0000_0000;
        dst_r[c] <= 32'h0000_0000;
        len_r[c] <= 32'h0000_0000;
        cfg_r[c] <= 32'h0000_0000;
        cnt_r[c] <= 32'h0000_0000;
        csrc_r[c] <= 32'h0000_0000;
        cdst_r[c] <= 32'h0000_0000;
      end
    end else begin
      if (rw_en && (rw_chan || rw_alt) && rw_ch < NCH) begin
        case (rw_reg)
          REG_SRC: src_r[rw_ch[CW-1:0]] <= rw_data;
          REG_DST: dst_r[rw_ch[CW-1:0]] <= rw_data;
          REG_LEN: len_r[rw_ch[CW-1:0]] <= rw_data;
          REG_CFG: cfg_r[rw_ch[CW-1:0]] <= rw_data;
          default: ;
        endcase
      end
      if (xfer_done) begin
        cnt_r[sel_r] <= s_last ? 32'h0000_0000
                               : cnt_r[sel_r] + 32'h0000_0001;
        // peripheral sides keep a fixed address
        if (s_ssel == 4'h0) begin
          csrc_r[sel_r] <= s_src + step(s_size);
        end
        if (s_dsel == 4'h0) begin
          cdst_r[sel_r] <= s_dst + step(s_size);
        end
        if (s_last && s_circ) begin
          csrc_r[sel_r] <= src_r[sel_r];
          cdst_r[sel_r] <= dst_r[sel_r];
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (start[c]) begin
          csrc_r[c] <= src_r[c];
          cdst_r[c] <= dst_r[c];
          cnt_r[c] <= 32'h0000_0000;
        end
      end
    end
  end
endmodule : dma_ll_device

// ==== logic/dma_ll_host.sv ====
// host end: apb master for commands plus memory answering the dma
`timescale 1ns/1ns
module dma_ll_host
  import dma_ll_pkg::*;
#(
  parameter int MEM_WORDS = HOST_MEM_WORDS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to device
  dma_link_if.host lnk,
  // register command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  output logic rsp_err,
  // peripheral request lines
  input wire logic [15:0] periph_req_in,
  output logic [15:0] periph_ack_out
);
  typedef enum {AP_IDLE, AP_SETUP, AP_ACCESS} apb_state_type;
  localparam int MW = $clog2(MEM_WORDS);

  apb_state_type ap_r;
  logic [31:0] paddr_r, pwdata_r, rdata_r, mrd_r;
  logic pwrite_r, rsp_valid_r, rsp_err_r, mack_r;
  logic [31:0] mem [MEM_WORDS];

  // list setup is a sequence of these commands, enable written last
  assign cmd_ready = (ap_r == AP_IDLE);
  assign lnk.psel = (ap_r != AP_IDLE);
  assign lnk.penable = (ap_r == AP_ACCESS);
  assign lnk.pwrite = pwrite_r;
  assign lnk.paddr = paddr_r;
  assign lnk.pwdata = pwdata_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rdata_r;
  assign rsp_err = rsp_err_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ap_r <= AP_IDLE;
      paddr_r <= 32'h0000_0000;
      pwdata_r <= 32'h0000_0000;
      pwrite_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rsp_valid_r <= 1'b0;
      rsp_err_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (ap_r)
        AP_IDLE: begin
          if (cmd_valid) begin
            paddr_r <= cmd_addr;
            pwdata_r <= cmd_wdata;
            pwrite_r <= cmd_write;
            ap_r <= AP_SETUP;
          end
        end
        AP_SETUP: ap_r <= AP_ACCESS;
        AP_ACCESS: begin
          if (lnk.pready) begin
            rdata_r <= lnk.prdata;
            rsp_err_r <= lnk.pslverr;
            rsp_valid_r <= 1'b1;
            ap_r <= AP_IDLE;
          end
        end
        default: ap_r <= AP_IDLE;
      endcase
    end
  end

  // memory answers one cycle after a request; the ack pulse also
  // drops the request phase so a held request is served only once
  wire [MW-1:0] widx = lnk.mem_addr[MW+1:2];
  wire take = lnk.mem_req && !mack_r;
  assign lnk.mem_ack = mack_r;
  assign lnk.mem_rdata = mrd_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mack_r <= 1'b0;
      mrd_r <= 32'h0000_0000;
    end else begin
      mack_r <= take;
      if (take) begin
        mrd_r <= mem[widx];
      end
    end
  end

  // storage has no reset; byte lanes honour the dma's size
  always_ff @(posedge clk) begin
    if (take && lnk.mem_we) begin
      for (int b = 0; b < 4; b++) begin
        if (lnk.mem_be[b]) begin
          mem[widx][8*b +: 8] <= lnk.mem_wdata[8*b +: 8];
        end
      end
    end
  end

  // lower channel moves blocks, upper follows the list
  assign lnk.periph_req = periph_req_in;
  assign periph_ack_out = lnk.periph_ack;
endmodule : dma_ll_host

// ==== logic/dma_ll_pkg.sv ====
// shared constants for the linked-list dma sequencer and its host end
// What this block does
// - software masks both list-channel completion bits
// - list channel: source=descriptor, destination=alternate source
// - list channel length is 4: five words
// - list channel: word memory copy, partner set
// - writing 1 to enable starts channel
// - list channel fetches five-word descriptor when enabled
// - list channel disables itself silently after fetch
// - finished list channel enables its partner channel
// - block channel moves elements, waits for peripherals
// - count reaching length clears count, sets status
// - finished block channel enables list channel if partnered
// - last entry moves one word then completes
// - last write may target the software interrupt
// - last entry has partner off: list stops
// - nonzero peripheral select paces by that peripheral
// - both selects nonzero: move while both request
// - software chooses per-block or end-of-list notice
// - descriptor words: source, dest, length, config, next
// - alternate registers consecutive across channel pair
// - lower channel handles blocks, higher follows list
package dma_ll_pkg;
  localparam int NCH_DEF = 2;
  localparam int NPERIPH = 16;
  localparam int DESC_WORDS = 5;
  localparam logic [31:0] LIST_LEN = 32'h0000_0004;
  // register window, as seen both by apb and by the dma's own writes
  localparam logic [19:0] REG_PAGE = 20'h80103;
  localparam logic [31:0] REG_BASE = {REG_PAGE, 12'h000};
  localparam logic [3:0] WIN_CHAN = 4'h0;
  localparam logic [3:0] WIN_ALT = 4'h2;
  localparam logic [3:0] WIN_GLOB = 4'hC;
  localparam int CH_IDX_LSB = 5;
  localparam int ALT_IDX_LSB = 4;
  localparam logic [11:0] CH_STRIDE = 12'h020;
  localparam logic [11:0] ALT_STRIDE = 12'h010;
  localparam logic [2:0] REG_SRC = 3'h0;
  localparam logic [2:0] REG_DST = 3'h1;
  localparam logic [2:0] REG_LEN = 3'h2;
  localparam logic [2:0] REG_CFG = 3'h3;
  localparam logic [2:0] REG_CNT = 3'h4;
  localparam logic [11:0] OFF_ALT = 12'h200;
  localparam logic [11:0] OFF_ENABLE = 12'hC00;
  localparam logic [11:0] OFF_STAT = 12'hC04;
  localparam logic [11:0] OFF_MASK = 12'hC08;
  localparam logic [11:0] OFF_SOFTINT = 12'hC10;
  // configuration word fields
  localparam int CFG_SIZE_LSB = 0;
  localparam int CFG_SSEL_LSB = 2;
  localparam int CFG_DSEL_LSB = 6;
  localparam int CFG_PCH_LSB = 10;
  localparam int CFG_PEN_BIT = 13;
  localparam int CFG_CIRC_BIT = 14;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  // status: bit 2c block done, bit 2c+1 half done, top bit software
  localparam int STAT_SOFT_BIT = 31;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam int HOST_MEM_WORDS = 1024;
endpackage : dma_ll_pkg

// ==== test/dma_ll_asserts.sv ====
// concurrent checks on the link between the dma device and its host end
`timescale 1ns/1ns
module dma_ll_asserts #(
  parameter int NCH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // system bus
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  // peripheral lines and channel state
  input wire logic [15:0] periph_req,
  input wire logic [15:0] periph_ack,
  input wire logic [NCH-1:0] chan_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ack_next: assert property (mem_req && !mem_ack |=> mem_ack)
    else $error("memory request not answered");
  chk_req_held: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request dropped early");
  chk_wdata_held: assert property (mem_req && mem_we && !mem_ack |=>
    $stable(mem_wdata))
    else $error("write data moved");
  chk_write_follows: assert property (mem_ack && !mem_we |=> mem_we)
    else $error("no write after read");
  chk_idle_gap: assert property (mem_ack && mem_we |=> !mem_req)
    else $error("no idle cycle after element");
  chk_stall_internal: assert property (psel && penable && !pready |->
    mem_we && !mem_req)
    else $error("stall without internal write");
  chk_err_zero: assert property (psel && penable && pslverr |->
    prdata == 32'h0)
    else $error("refused access returned data");
  chk_runs_enabled: assert property (mem_req |-> chan_active != '0)
    else $error("bus traffic with no channel on");
  chk_done_disables: assert property ($fell(chan_active[0]) |->
    $past(mem_ack) || $past(mem_ack, 2))
    else $error("channel stopped without element done");
  chk_ack_requested: assert property (periph_ack != 16'h0 |->
    (periph_ack & ~periph_req) == 16'h0)
    else $error("acknowledge to idle peripheral");

  cov_write: cover property (mem_ack && mem_we);
  cov_refused: cover property (psel && penable && pslverr);
  cov_paced: cover property (periph_ack != 16'h0);
endmodule : dma_ll_asserts

// ==== test/tb.sv ====
// bench: command port traffic on one pair, a linked list on a second device
`timescale 1ns/1ns
module tb;
  import dma_ll_pkg::*;
  logic clk;
  logic rst;
  logic cmd_valid;
  logic cmd_write;
  logic [31:0] cmd_addr;
  logic [31:0] cmd_wdata;
  logic cmd_ready;
  logic rsp_valid;
  logic [31:0] rsp_rdata;
  logic rsp_err;
  logic [15:0] periph_req_in;
  logic [15:0] periph_ack_out;
  logic irq_a;
  logic irq_b;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic [31:0] mem2 [0:63];
  logic [31:0] rd_addr [$];
  logic [7:0] rd_exp [13] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h80,
    8'h84, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h88};
  logic [31:0] rd;
  logic err;
  logic [15:0] ack_seen;
  logic s_req;
  logic s_we;
  logic [31:0] s_addr;
  logic [31:0] s_wdata;
  int wr_a;
  int wr_b;
  int base;
  int tries;
  int n_mismatch;
  int check_count;

  dma_link_if if_a ();
  dma_link_if if_b ();
  dma_ll_device #(.NCH(2)) dma_ll_device_inst (.clk(clk), .rst(rst),
    .lnk(if_a.dev), .irq(irq_a), .chan_active(act_a));
  dma_ll_host #(.MEM_WORDS(1024)) dma_ll_host_inst (.clk(clk), .rst(rst),
    .lnk(if_a.host), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
    .periph_req_in(periph_req_in), .periph_ack_out(periph_ack_out));
  // second device faces the bench, so list memory holds known words
  dma_ll_device #(.NCH(2)) dma_ll_device_inst_list (.clk(clk), .rst(rst),
    .lnk(if_b.dev), .irq(irq_b), .chan_active(act_b));
  dma_ll_asserts #(.NCH(2)) dma_ll_asserts_inst (.clk(clk), .rst(rst),
    .psel(if_a.psel), .penable(if_a.penable), .pready(if_a.pready),
    .pslverr(if_a.pslverr), .prdata(if_a.prdata), .mem_req(if_a.mem_req),
    .mem_we(if_a.mem_we), .mem_addr(if_a.mem_addr),
    .mem_wdata(if_a.mem_wdata), .mem_ack(if_a.mem_ack),
    .periph_req(if_a.periph_req), .periph_ack(if_a.periph_ack),
    .chan_active(act_a));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // sample requests mid-cycle so the answer never races the request flops
  always @(negedge clk) begin
    s_req = if_b.mem_req && !if_b.mem_ack;
    s_we = if_b.mem_we;
    s_addr = if_b.mem_addr;
    s_wdata = if_b.mem_wdata;
    if (if_a.mem_ack && if_a.mem_we) wr_a++;
    ack_seen = ack_seen | periph_ack_out;
  end

  // bench memory: data bus toggles when idle rather than holding old data
  always @(posedge clk) begin
    if_b.mem_ack <= 1'b0;
    if_b.mem_rdata <= ~if_b.mem_rdata;
    if (!rst && s_req) begin
      if_b.mem_ack <= 1'b1;
      if (s_we) begin
        mem2[s_addr[7:2]] <= s_wdata;
        wr_b <= wr_b + 1;
      end else begin
        if_b.mem_rdata <= mem2[s_addr[7:2]];
        rd_addr.push_back(s_addr);
      end
    end
  end

  function automatic logic [31:0] ra(input logic [11:0] off);
    return REG_BASE | {20'h0, off};
  endfunction : ra

  function automatic logic [31:0] cr(input int c, input logic [2:0] r);
    return ra(12'(c) * CH_STRIDE + {7'h0, r, 2'b00});
  endfunction : cr

  function automatic logic [31:0] cfg(input logic [3:0] ss,
    input logic [3:0] ds, input logic [2:0] pch, input logic pen);
    return (32'(SIZE_WORD) << CFG_SIZE_LSB) | (32'(ss) << CFG_SSEL_LSB) |
      (32'(ds) << CFG_DSEL_LSB) | (32'(pch) << CFG_PCH_LSB) |
      (32'(pen) << CFG_PEN_BIT);
  endfunction : cfg

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 50);
    rd = rsp_rdata;
    err = rsp_err;
  endtask : acc

  task automatic bus(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    if_b.psel <= 1'b1;
    if_b.pwrite <= w;
    if_b.paddr <= a;
    if_b.pwdata <= d;
    @(posedge clk);
    if_b.penable <= 1'b1;
    n = 0;
    // pready and read data are taken at the rising edge that ends access
    do begin
      @(posedge clk);
      n++;
    end while (if_b.pready !== 1'b1 && n < 50);
    rd = if_b.prdata;
    if_b.psel <= 1'b0;
    if_b.penable <= 1'b0;
  endtask : bus

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      acc(1'b0, ra(OFF_ENABLE), 32'h0);
      n++;
    end while (rd !== 32'h0 && n < 100);
    check(rd, 32'h0);
  endtask : wait_idle

  task automatic conclude;
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end

  initial begin
    {rst, cmd_valid, cmd_write, cmd_addr, cmd_wdata} = {2'b10, 65'h0};
    {if_b.psel, if_b.penable, if_b.pwrite, if_b.paddr, if_b.pwdata} = '0;
    {if_b.mem_rdata, if_b.mem_ack, if_b.periph_req} = '0;
    {periph_req_in, ack_seen, s_req} = '0;
    {wr_a, wr_b, n_mismatch, check_count} = '0;
    for (int i = 0; i < 64; i++) mem2[i] = 32'h5A00_0000 + 32'(i * 257);
    mem2[0:4] = '{32'h80, 32'hC0, 32'h1, cfg(0, 0, 3'h1, 1'b1), 32'h40};
    mem2[16:20] = '{32'h88, ra(OFF_SOFTINT), 32'h0, cfg(0, 0, 0, 0), 32'hF0};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, ra(OFF_MASK), 0);
    check(rd, MASK_RST);
    acc(1'b0, ra(OFF_ENABLE), 0);
    check(rd, 32'h0);
    acc(1'b0, cr(2, REG_SRC), 0);
    check({err, rd[30:0]}, 32'h8000_0000);
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, ra(OFF_ALT + 12'(4 * k)), 32'h1111_0000 + 32'(k));
      acc(1'b0, k < 4 ? cr(0, 3'(k)) : cr(1, REG_SRC), 0);
      check(rd, 32'h1111_0000 + 32'(k));
    end
    // three words, the first into the software interrupt and two into the next offsets: internal writes stall apb
    acc(1'b1, cr(0, REG_SRC), 32'h100);
    acc(1'b1, cr(0, REG_DST), ra(OFF_SOFTINT));
    acc(1'b1, cr(0, REG_LEN), 32'h2);
    acc(1'b1, cr(0, REG_CFG), cfg(0, 0, 0, 0));
    acc(1'b1, ra(OFF_ENABLE), 32'h1);
    wait_idle();
    check(32'(wr_a), 32'h0);
    acc(1'b0, ra(OFF_STAT), 0);
    check(rd & 32'h8000_0001, 32'h8000_0001);
    acc(1'b0, cr(0, REG_CNT), 0);
    check(rd, 32'h0);
    check({31'h0, irq_a}, 32'h0);
    acc(1'b1, ra(OFF_MASK), 32'h7FFF_FFFF);
    check({31'h0, irq_a}, 32'h1);
    // the half-done bit of channel 0 is masked but is cleared here as well
    acc(1'b1, ra(OFF_STAT), 32'h8000_0003);
    check({31'h0, irq_a}, 32'h0);
    // first pass: source paced only; second: both ends paced
    for (int k = 0; k < 2; k++) begin
      acc(1'b1, cr(0, REG_DST), 32'h300);
      acc(1'b1, cr(0, REG_LEN), 32'h0);
      acc(1'b1, cr(0, REG_CFG), cfg(4'h3, k ? 4'h5 : 4'h0, 0, 0));
      @(posedge clk);
      periph_req_in <= k ? 16'h0020 : 16'h0000;
      ack_seen = '0;
      base = wr_a;
      acc(1'b1, ra(OFF_ENABLE), 32'h1);
      repeat (30) @(posedge clk);
      check(32'(wr_a), 32'(base));
      periph_req_in <= k ? 16'h0028 : 16'h0008;
      wait_idle();
      check(32'(wr_a), 32'(base + 1));
      check({16'h0, ack_seen & 16'h0028}, k ? 32'h28 : 32'h8);
    end
    bus(1'b1, ra(OFF_MASK), 32'h7FFF_FFFE);
    bus(1'b1, cr(1, REG_SRC), 32'h0);
    bus(1'b1, cr(1, REG_DST), ra(OFF_ALT));
    bus(1'b1, cr(1, REG_LEN), LIST_LEN);
    bus(1'b1, cr(1, REG_CFG), cfg(0, 0, 0, 1'b1));
    bus(1'b1, ra(OFF_ENABLE), 32'h2);
    tries = 0;
    do begin
      bus(1'b0, ra(OFF_STAT), 0);
      tries++;
    end while (rd[STAT_SOFT_BIT] !== 1'b1 && tries < 200);
    check(rd & 32'h8000_0001, 32'h8000_0001);
    bus(1'b0, ra(OFF_ENABLE), 0);
    check(rd, 32'h0);
    check(32'(rd_addr.size()), 32'd13);
    for (int i = 0; i < 13 && i < rd_addr.size(); i++)
      check(rd_addr[i], {24'h0, rd_exp[i]});
    check(mem2[48], 32'h5A00_0000 + 32'(32 * 257));
    check(mem2[49], 32'h5A00_0000 + 32'(33 * 257));
    check(32'(wr_b), 32'd2);
    bus(1'b0, cr(0, REG_DST), 0);
    check(rd, ra(OFF_SOFTINT));
    bus(1'b0, cr(1, REG_SRC), 0);
    check(rd, 32'hF0);
    check({31'h0, irq_b}, 32'h1);
    conclude();
  end
endmodule : tb
